// *** fsrm_core.sv ***
/*
 * status bytes, reset sources, compatibility modes and dma request logic
 * of the floppy controller core.
 * assumes all inputs are synchronous to i_clock; i_rst is power-on reset.
 */
// Notes on behaviour
// - cm flag set on deleted mark in normal read, or normal mark in deleted read
// - dd flag set on data field crc mismatch
// - wc flag set when id cylinder differs from internal cylinder
// - bc flag set when cylinder mismatches and equals ff
// - md flag set when no data or deleted data mark found
// - unused status bits: st2 7,3,2 and st3 7 zero; st3 5,3 one
// - st3 bit 6 follows write-protect pin
// - st3 bit 4 follows track-zero pin
// - st3 bit 2 follows head select, bits 1,0 follow drive selects
// - pin, dor and dsr resets plus power-on; every reset exits power-down
// - pin reset aborts all operations and idles the controller
// - leaving reset clears configure settings and restarts drive polling
// - pin reset clears all but specify settings and sets dor reset bit
// - both software resets reset core and drive status
// - dsr reset bit self-clears; dor reset bit held until host clears
// - dor reset takes precedence over dsr reset
// - three modes from interface-mode field bits 3,2 of f0
// - first mode: dor dma bit gates int and dma; density active high
// - second mode: dor dma ignored, int and dma on; density active low
// - third mode: dor dma bit gates int and dma; density active low
// - dma enabled by specify; controller raises request for read, write, verify
// - single and burst dma; burst from f0 bit 1
// - density output high after hardware reset, untouched by software resets
`timescale 1ns/10ps
`default_nettype none
`include "fsrm_cfg.svh"

module fsrm_core (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_hardware_reset_n,
    input  wire logic       i_dor_wr,
    input  wire logic       i_dor_reset,
    input  wire logic       i_dor_dma_en,
    input  wire logic       i_dsr_wr,
    input  wire logic       i_dsr_reset,
    input  wire logic       i_cfg_wr,
    input  wire logic [7:0] i_floppy_config_reg_f0,
    input  wire logic       i_specify_wr,
    input  wire logic       i_specify_dma,
    input  wire logic       i_configure_wr,
    input  wire logic       i_configure_poll_off,
    input  wire logic       i_powerdown_req,
    input  wire logic       i_rate_wr,
    input  wire logic       i_density_high,
    input  wire logic       i_status_clear,
    input  wire logic       i_mark_seen,
    input  wire logic       i_mark_deleted,
    input  wire logic       i_cmd_deleted,
    input  wire logic       i_crc_bad,
    input  wire logic       i_id_check,
    input  wire logic [7:0] i_id_cyl,
    input  wire logic [7:0] i_internal_cyl,
    input  wire logic       i_mark_missing,
    input  wire logic       i_sel_wr,
    input  wire logic       i_head_sel,
    input  wire logic [1:0] i_drive_sel,
    input  wire logic       i_write_protect_in,
    input  wire logic       i_track_zero_in,
    input  wire logic       i_int_req,
    input  wire logic       i_xfer_req,
    input  wire logic       i_dma_ack,
    output logic [7:0]      o_result_status_byte_two,
    output logic [7:0]      o_result_status_byte_three,
    output logic            o_head_select_out,
    output logic            o_drive_select_hi_out,
    output logic            o_drive_select_lo_out,
    output logic            o_density_select_out,
    output logic            o_int_out,
    output logic            o_dma_req,
    output logic            o_core_reset,
    output logic            o_dor_reset_bit,
    output logic            o_power_down,
    output logic            o_drive_poll_en
);

    function automatic fsrm_pkg::fsrm_mode_e mode_of(input logic [1:0] code);
        if (code == `FSRM_MODE_SECOND) begin
            mode_of = fsrm_pkg::FSRM_MODE_B;
        end else if (code == `FSRM_MODE_THIRD) begin
            mode_of = fsrm_pkg::FSRM_MODE_C;
        end else begin
            mode_of = fsrm_pkg::FSRM_MODE_A; // reserved code falls here
        end
    endfunction

    logic                  dor_reset_ff;
    logic                  dsr_reset_ff;
    logic [7:0]            f0_ff;
    logic                  specify_dma_ff;
    logic                  dor_dma_ff;
    logic                  poll_off_ff;
    logic [7:0]            st2_ff;
    logic                  head_ff;
    logic [1:0]            drv_ff;
    logic                  dens_want_ff;
    fsrm_pkg::fsrm_dma_e   dma_st_ff;
    fsrm_pkg::fsrm_dma_e   nxt_dma_st;

    // reset sources
    wire pin_rst = ~i_hardware_reset_n;
    wire core_rst = pin_rst | dor_reset_ff | dsr_reset_ff;
    fsrm_pkg::fsrm_src_e rst_src;
    assign rst_src = pin_rst ? fsrm_pkg::FSRM_SRC_PIN :
                     dor_reset_ff ? fsrm_pkg::FSRM_SRC_DOR :
                     dsr_reset_ff ? fsrm_pkg::FSRM_SRC_DSR : fsrm_pkg::FSRM_SRC_NONE;

    // mode decode
    wire [1:0] mode_code = f0_ff[`FSRM_F0_MODE_HI:`FSRM_F0_MODE_LO];
    fsrm_pkg::fsrm_mode_e mode;
    assign mode = mode_of(mode_code);
    wire gate_on = (mode == fsrm_pkg::FSRM_MODE_B) ? 1'b1 : dor_dma_ff;
    wire dens_act_hi = (mode == fsrm_pkg::FSRM_MODE_A);
    wire burst = f0_ff[`FSRM_F0_BURST];
    wire dma_live = gate_on & specify_dma_ff & ~core_rst;

    // status event decode
    wire ev_cm = i_mark_seen & (i_mark_deleted ^ i_cmd_deleted);
    wire cyl_diff = i_id_check & (i_id_cyl != i_internal_cyl);
    wire ev_bc = cyl_diff & (i_id_cyl == `FSRM_BAD_CYL);
    logic [7:0] st2_set;
    always_comb begin
        st2_set = 8'h00;
        st2_set[`FSRM_ST2_CM] = ev_cm;
        st2_set[`FSRM_ST2_DD] = i_crc_bad;
        st2_set[`FSRM_ST2_WC] = cyl_diff;
        st2_set[`FSRM_ST2_BC] = ev_bc;
        st2_set[`FSRM_ST2_MD] = i_mark_missing;
    end
    // set wins over clear so an event in the clearing cycle is kept
    wire [7:0] nxt_st2 = (i_status_clear ? 8'h00 : st2_ff) | st2_set;

    logic [7:0] st3_now;
    always_comb begin
        st3_now = `FSRM_ST3_RESET;
        st3_now[`FSRM_ST3_WP] = i_write_protect_in;
        st3_now[`FSRM_ST3_T0] = i_track_zero_in;
        st3_now[`FSRM_ST3_HD] = head_ff;
        st3_now[1:0] = drv_ff;
    end

    // dor reset bit: set by the pin, held until the host writes zero
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dor_reset_ff <= 1'b1;
        end else if (pin_rst) begin
            dor_reset_ff <= 1'b1;
        end else if (i_dor_wr) begin
            dor_reset_ff <= i_dor_reset;
        end
    end

    // dsr reset bit clears itself one cycle after the write
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dsr_reset_ff <= 1'b0;
        end else begin
            dsr_reset_ff <= i_dsr_wr & i_dsr_reset & ~pin_rst;
        end
    end

    // specify settings survive the pin reset; only power-on clears them
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            specify_dma_ff <= 1'b0;
        end else if (i_specify_wr) begin
            specify_dma_ff <= i_specify_dma;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            f0_ff <= `FSRM_F0_RESET;
        end else if (pin_rst) begin
            f0_ff <= `FSRM_F0_RESET;
        end else if (i_cfg_wr) begin
            f0_ff <= i_floppy_config_reg_f0;
        end
    end

    // dor dma bit is a dor field, so only the pin and power-on clear it
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dor_dma_ff <= 1'b0;
        end else if (pin_rst) begin
            dor_dma_ff <= 1'b0;
        end else if (i_dor_wr) begin
            dor_dma_ff <= i_dor_dma_en;
        end
    end

    // configure info and polling restart on any reset
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            poll_off_ff <= 1'b0;
        end else if (core_rst) begin
            poll_off_ff <= 1'b0;
        end else if (i_configure_wr) begin
            poll_off_ff <= i_configure_poll_off;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_power_down <= 1'b0;
        end else if (core_rst) begin
            o_power_down <= 1'b0;
        end else if (i_powerdown_req) begin
            o_power_down <= 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st2_ff <= `FSRM_ST2_RESET;
        end else if (core_rst) begin
            st2_ff <= `FSRM_ST2_RESET;
        end else begin
            st2_ff <= nxt_st2;
        end
    end

    // drive and head selects are drive status, cleared by every reset
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            head_ff <= 1'b0;
            drv_ff  <= 2'h0;
        end else if (core_rst) begin
            head_ff <= 1'b0;
            drv_ff  <= 2'h0;
        end else if (i_sel_wr) begin
            head_ff <= i_head_sel;
            drv_ff  <= i_drive_sel;
        end
    end

    // density request is a rate setting; software resets leave it alone
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dens_want_ff <= `FSRM_DENS_RESET;
        end else if (pin_rst) begin
            dens_want_ff <= `FSRM_DENS_RESET;
        end else if (i_rate_wr) begin
            dens_want_ff <= i_density_high;
        end
    end

    // pin stays high until the first rate write after a hardware reset
    logic dens_hold_ff;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dens_hold_ff <= 1'b1;
        end else if (pin_rst) begin
            dens_hold_ff <= 1'b1;
        end else if (i_rate_wr) begin
            dens_hold_ff <= 1'b0;
        end
    end
    // the pin itself forces the level so the edge it is seen already drives high
    wire nxt_dens = (dens_hold_ff | pin_rst) ? `FSRM_DENS_RESET :
                    (dens_act_hi ? dens_want_ff : ~dens_want_ff);

    // dma request: burst holds it while data is wanted, single drops it
    // for two cycles after every acknowledge
    always_comb begin
        nxt_dma_st = dma_st_ff;
        case (dma_st_ff)
            fsrm_pkg::FSRM_DMA_IDLE: begin
                if (dma_live & i_xfer_req) begin
                    nxt_dma_st = fsrm_pkg::FSRM_DMA_REQ;
                end
            end
            fsrm_pkg::FSRM_DMA_REQ: begin
                if (~dma_live | ~i_xfer_req) begin
                    nxt_dma_st = fsrm_pkg::FSRM_DMA_IDLE;
                end else if (i_dma_ack & ~burst) begin
                    nxt_dma_st = fsrm_pkg::FSRM_DMA_GAP;
                end
            end
            default: begin
                nxt_dma_st = fsrm_pkg::FSRM_DMA_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dma_st_ff <= fsrm_pkg::FSRM_DMA_IDLE;
        end else if (core_rst) begin
            dma_st_ff <= fsrm_pkg::FSRM_DMA_IDLE;
        end else begin
            dma_st_ff <= nxt_dma_st;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_result_status_byte_two   <= `FSRM_ST2_RESET;
            o_result_status_byte_three <= `FSRM_ST3_RESET;
            o_head_select_out          <= 1'b0;
            o_drive_select_hi_out      <= 1'b0;
            o_drive_select_lo_out      <= 1'b0;
            o_density_select_out       <= `FSRM_DENS_RESET;
            o_int_out                  <= 1'b0;
            o_dma_req                  <= 1'b0;
            o_core_reset               <= 1'b1;
            o_dor_reset_bit            <= 1'b1;
            o_drive_poll_en            <= 1'b0;
        end else begin
            o_result_status_byte_two   <= st2_ff;
            o_result_status_byte_three <= st3_now;
            o_head_select_out          <= head_ff;
            o_drive_select_hi_out      <= drv_ff[1];
            o_drive_select_lo_out      <= drv_ff[0];
            o_density_select_out       <= nxt_dens;
            o_int_out                  <= i_int_req & gate_on & ~core_rst;
            o_dma_req                  <= (nxt_dma_st == fsrm_pkg::FSRM_DMA_REQ) & ~core_rst;
            o_core_reset               <= core_rst;
            o_dor_reset_bit            <= dor_reset_ff;
            o_drive_poll_en            <= ~core_rst & ~poll_off_ff;
        end
    end

    // checks
    a_cm_flag_set: assert property (@(posedge i_clock) disable iff (i_rst)
        (ev_cm & ~core_rst) |=> ##1 o_result_status_byte_two[`FSRM_ST2_CM])
        else $error("cm flag not raised");
    a_dd_flag_set: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_crc_bad & ~core_rst) |=> ##1 o_result_status_byte_two[`FSRM_ST2_DD])
        else $error("dd flag not raised");
    a_wc_bc_pair: assert property (@(posedge i_clock) disable iff (i_rst)
        o_result_status_byte_two[`FSRM_ST2_BC] |-> o_result_status_byte_two[`FSRM_ST2_WC])
        else $error("bc without wc");
    a_unused_bits: assert property (@(posedge i_clock) disable iff (i_rst)
        o_result_status_byte_two[7] == 1'b0 && o_result_status_byte_two[3:2] == 2'h0 &&
        o_result_status_byte_three[7] == 1'b0 && o_result_status_byte_three[5] &&
        o_result_status_byte_three[3])
        else $error("unused status bits wrong");
    a_wp_track: assert property (@(posedge i_clock) disable iff (i_rst)
        ##1 o_result_status_byte_three[`FSRM_ST3_WP] == $past(i_write_protect_in))
        else $error("wp bit not following pin");
    a_t0_track: assert property (@(posedge i_clock) disable iff (i_rst)
        ##1 o_result_status_byte_three[`FSRM_ST3_T0] == $past(i_track_zero_in))
        else $error("t0 bit not following pin");
    a_sel_mirror: assert property (@(posedge i_clock) disable iff (i_rst)
        o_result_status_byte_three[1:0] == {o_drive_select_hi_out, o_drive_select_lo_out} &&
        o_result_status_byte_three[`FSRM_ST3_HD] == o_head_select_out)
        else $error("select bits differ from pins");
    a_pin_sets_dor: assert property (@(posedge i_clock) disable iff (i_rst)
        pin_rst |=> ##1 o_dor_reset_bit && o_core_reset)
        else $error("pin reset did not set dor bit");
    a_dsr_selfclr: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_dsr_wr & i_dsr_reset & ~pin_rst) |=> dsr_reset_ff ##1 !dsr_reset_ff)
        else $error("dsr reset did not self-clear");
    a_dor_holds: assert property (@(posedge i_clock) disable iff (i_rst)
        (dor_reset_ff & ~i_dor_wr & ~pin_rst) |=> dor_reset_ff)
        else $error("dor reset dropped without a write");
    a_dor_over_dsr: assert property (@(posedge i_clock) disable iff (i_rst)
        (dor_reset_ff && dsr_reset_ff && !i_dor_wr) |=> ##1 o_core_reset)
        else $error("dsr self-clear ended a dor reset");
    a_mode_b_int: assert property (@(posedge i_clock) disable iff (i_rst)
        (mode == fsrm_pkg::FSRM_MODE_B && i_int_req && !core_rst) |=> o_int_out)
        else $error("second mode did not pass interrupt");
    a_gated_int: assert property (@(posedge i_clock) disable iff (i_rst)
        (mode != fsrm_pkg::FSRM_MODE_B && !dor_dma_ff) |=> !o_int_out)
        else $error("interrupt passed with dma bit off");
    a_no_dma_nospec: assert property (@(posedge i_clock) disable iff (i_rst)
        !specify_dma_ff |=> !o_dma_req)
        else $error("dma request without specify");
    a_single_gap: assert property (@(posedge i_clock) disable iff (i_rst)
        (dma_st_ff == fsrm_pkg::FSRM_DMA_REQ && i_dma_ack && !burst && dma_live &&
         i_xfer_req) |=> !o_dma_req)
        else $error("single mode kept request");
    a_dens_pin_rst: assert property (@(posedge i_clock) disable iff (i_rst)
        pin_rst |=> o_density_select_out)
        else $error("density not high after pin reset");

    c_burst_run: cover property (@(posedge i_clock) disable iff (i_rst)
        burst && o_dma_req && i_dma_ack ##1 o_dma_req && i_dma_ack);
    c_dor_over_dsr: cover property (@(posedge i_clock) disable iff (i_rst)
        rst_src == fsrm_pkg::FSRM_SRC_DOR && dsr_reset_ff);
    c_bad_cyl: cover property (@(posedge i_clock) disable iff (i_rst)
        o_result_status_byte_two[`FSRM_ST2_BC]);
    c_mode_c_int: cover property (@(posedge i_clock) disable iff (i_rst)
        mode == fsrm_pkg::FSRM_MODE_C && o_int_out);

endmodule
`default_nettype wire

// *** fsrm_cfg.svh ***
/*
 * constants for the floppy status, reset and mode block: field positions,
 * reset values and interface-mode codes.
 * assumes it is included by bare name from the package and the core.
 */
`ifndef FSRM_CFG_SVH
`define FSRM_CFG_SVH

// third result status byte
`define FSRM_ST2_CM      6
`define FSRM_ST2_DD      5
`define FSRM_ST2_WC      4
`define FSRM_ST2_BC      1
`define FSRM_ST2_MD      0
`define FSRM_ST2_RESET   8'h00
// fourth result status byte
`define FSRM_ST3_WP      6
`define FSRM_ST3_ONE_HI  5
`define FSRM_ST3_T0      4
`define FSRM_ST3_ONE_LO  3
`define FSRM_ST3_HD      2
`define FSRM_ST3_RESET   8'h28
// bad track cylinder marker
`define FSRM_BAD_CYL     8'hff
// floppy_config_reg_f0 fields
`define FSRM_F0_MODE_HI  3
`define FSRM_F0_MODE_LO  2
`define FSRM_F0_BURST    1
`define FSRM_F0_RESET    8'h00
// interface-mode field codes
`define FSRM_MODE_FIRST  2'h0
`define FSRM_MODE_SECOND 2'h1
`define FSRM_MODE_THIRD  2'h2
// density-select level after a hardware reset
`define FSRM_DENS_RESET  1'b1

`endif

// *** fsrm_pkg.sv ***
/*
 * types for the floppy status, reset and mode block.
 * assumes fsrm_cfg.svh is available on the include path.
 */
`include "fsrm_cfg.svh"

package fsrm_pkg;

    typedef enum logic [1:0] {
        FSRM_MODE_A,
        FSRM_MODE_B,
        FSRM_MODE_C
    } fsrm_mode_e;

    typedef enum logic [1:0] {
        FSRM_DMA_IDLE,
        FSRM_DMA_REQ,
        FSRM_DMA_GAP
    } fsrm_dma_e;

    typedef enum logic [1:0] {
        FSRM_SRC_NONE,
        FSRM_SRC_PIN,
        FSRM_SRC_DOR,
        FSRM_SRC_DSR
    } fsrm_src_e;

endpackage

// *** fsrm_drive_model.sv ***
/*
 * model of the far side of fsrm_core: drive pins and the host dma controller.
 * assumes it shares i_clock with the core; the bench sets the pin levels and
 * the stall input that slows the dma answer.
 */
`timescale 1ns/10ps
`default_nettype none
module fsrm_drive_model (
    input  wire logic i_clock,
    input  wire logic i_dma_req,
    input  wire logic i_stall,
    input  wire logic i_wp_level,
    input  wire logic i_t0_level,
    output logic      o_dma_ack,
    output logic      o_write_protect_in,
    output logic      o_track_zero_in
);
    initial o_dma_ack = 1'h0;
    // one acked cycle per byte: ack is dropped after the byte moves, never left standing
    always @(posedge i_clock) begin
        o_dma_ack <= i_dma_req & ~o_dma_ack & ~i_stall;
    end
    assign o_write_protect_in = i_wp_level;
    assign o_track_zero_in    = i_t0_level;
endmodule
`default_nettype wire

// *** testbench.sv ***
/*
 * self-checking bench for fsrm_core: status bytes, reset sources, modes, dma.
 * assumes fsrm_core and fsrm_drive_model are compiled first; one 100 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic       i_clock = 1'h0;
    logic       i_rst, hw_n, dor_wr, dor_rst, dor_dma, dsr_wr, dsr_rst, cfg_wr, spec_wr;
    logic       spec_dma, conf_wr, poll_off, pd_req, rate_wr, dens_hi, st_clr, ms, md, cd;
    logic       crc, idc, mm, sel_wr, head, int_req, xfer, stall, wp, t0, gate;
    logic [1:0] dsel;
    logic [7:0] f0, id_cyl, in_cyl, exp_two, st2, st3;
    logic       hd_o, ds_hi, ds_lo, dens_o, int_o, dreq, core_rst, dor_bit, pdown, poll;
    logic       ack, wp_pin, t0_pin, dx;
    int         err_count = 0, samples_checked = 0, seed = 32'hd488;

    always #5 i_clock = ~i_clock;

    fsrm_core i_fsrm_core (
        .i_clock(i_clock), .i_rst(i_rst), .i_hardware_reset_n(hw_n), .i_dor_wr(dor_wr),
        .i_dor_reset(dor_rst), .i_dor_dma_en(dor_dma), .i_dsr_wr(dsr_wr), .i_dsr_reset(dsr_rst),
        .i_cfg_wr(cfg_wr), .i_floppy_config_reg_f0(f0), .i_specify_wr(spec_wr),
        .i_specify_dma(spec_dma), .i_configure_wr(conf_wr), .i_configure_poll_off(poll_off),
        .i_powerdown_req(pd_req), .i_rate_wr(rate_wr), .i_density_high(dens_hi),
        .i_status_clear(st_clr), .i_mark_seen(ms), .i_mark_deleted(md), .i_cmd_deleted(cd),
        .i_crc_bad(crc), .i_id_check(idc), .i_id_cyl(id_cyl), .i_internal_cyl(in_cyl),
        .i_mark_missing(mm), .i_sel_wr(sel_wr), .i_head_sel(head), .i_drive_sel(dsel),
        .i_write_protect_in(wp_pin), .i_track_zero_in(t0_pin), .i_int_req(int_req),
        .i_xfer_req(xfer), .i_dma_ack(ack), .o_result_status_byte_two(st2),
        .o_result_status_byte_three(st3), .o_head_select_out(hd_o),
        .o_drive_select_hi_out(ds_hi), .o_drive_select_lo_out(ds_lo),
        .o_density_select_out(dens_o), .o_int_out(int_o), .o_dma_req(dreq),
        .o_core_reset(core_rst), .o_dor_reset_bit(dor_bit), .o_power_down(pdown),
        .o_drive_poll_en(poll)
    );

    fsrm_drive_model i_fsrm_drive_model (
        .i_clock(i_clock), .i_dma_req(dreq), .i_stall(stall), .i_wp_level(wp),
        .i_t0_level(t0), .o_dma_ack(ack), .o_write_protect_in(wp_pin), .o_track_zero_in(t0_pin)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // inputs always move 1 ns after the edge so the core never races the bench
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic strobe(ref logic s);
        s = 1'h1;
        tick(1);
        s = 1'h0;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic [7:0] exp_st2(input logic s, dl, cdl, cb, ic, input logic [7:0] a,
                                           input logic [7:0] b, input logic mis);
        logic wc;
        wc = ic & (a != b);
        return {1'h0, s & (dl ^ cdl), cb, wc, 2'h0, wc & (a == 8'hff), mis};
    endfunction

    // single mode must leave a gap after every byte; burst keeps the request up
    task automatic dma_run(input logic burst);
        int moves;
        moves = 0;
        xfer = 1'h1;
        tick(2);
        repeat (24) begin
            if (!burst) stall = 1'($random(seed));
            if (dreq === 1'h1 && ack === 1'h1) begin
                moves++;
                tick(1);
                if (!burst) check("single gap", dreq, 1'h0);
            end else begin
                tick(1);
            end
            if (burst) check("burst hold", dreq, 1'h1);
        end
        xfer = 1'h0;
        stall = 1'h0;
        tick(3);
        check("bytes moved", 8'(moves > 0), 8'h01);
        check("request drop", dreq, 1'h0);
    endtask

    initial begin
        #50000;
        err_count++;
        results();
    end

    initial begin
        {i_rst, hw_n} = 2'h3;
        {dor_wr, dor_rst, dor_dma, dsr_wr, dsr_rst, cfg_wr, spec_wr, spec_dma, conf_wr} = '0;
        {poll_off, pd_req, rate_wr, dens_hi, st_clr, ms, md, cd, crc, idc, mm, sel_wr} = '0;
        {head, int_req, xfer, stall, wp, t0, dsel, f0, id_cyl, in_cyl} = '0;
        tick(8);
        i_rst = 1'h0;
        tick(1);
        check("status two at reset", st2, 8'h00);
        check("status three at reset", st3, 8'h28);
        check("reset bit after power on", dor_bit, 1'h1);
        check("density after power on", dens_o, 1'h1);
        check("core held", core_rst, 1'h1);
        dor_dma = 1'h1;
        strobe(dor_wr);
        tick(2);
        check("core released", core_rst, 1'h0);
        check("polling", poll, 1'h1);
        spec_dma = 1'h1;
        strobe(spec_wr);
        for (int k = 0; k < 40; k++) begin
            {ms, md, cd, crc, idc, mm} = 6'($random(seed));
            id_cyl = (k % 3 == 0) ? 8'hff : 8'($random(seed));
            in_cyl = (k % 4 == 0) ? id_cyl : 8'($random(seed));
            exp_two = exp_st2(ms, md, cd, crc, idc, id_cyl, in_cyl, mm);
            tick(1);
            {ms, md, cd, crc, idc, mm} = '0;
            tick(1);
            check("status two", st2, exp_two);
            strobe(st_clr);
            tick(1);
            check("status two cleared", st2, 8'h00);
        end
        for (int k = 0; k < 16; k++) begin
            {head, dsel, wp, t0} = 5'($random(seed));
            strobe(sel_wr);
            tick(2);
            exp_two = {1'h0, wp, 1'h1, t0, 1'h1, head, dsel};
            check("status three", st3, exp_two);
            check("select pins", {hd_o, ds_hi, ds_lo}, {head, dsel});
        end
        {stall, xfer, int_req} = 3'h7;
        for (int m = 0; m < 4; m++) begin
            for (int d = 0; d < 2; d++) begin
                f0 = {4'h0, 2'(m), 2'h0};
                strobe(cfg_wr);
                dens_hi = 1'($random(seed));
                strobe(rate_wr);
                dor_dma = 1'(d);
                strobe(dor_wr);
                tick(3);
                gate = (m == 1) || (d == 1);
                dx = dens_hi ^ (m == 1 || m == 2);
                check("density", dens_o, dx);
                check("interrupt", int_o, gate);
                check("dma gate", dreq, gate);
            end
        end
        {stall, xfer, int_req} = 3'h0;
        tick(2);
        dma_run(1'h0);
        f0 = 8'h02;
        strobe(cfg_wr);
        dma_run(1'h1);
        strobe(crc);
        strobe(pd_req);
        poll_off = 1'h1;
        strobe(conf_wr);
        tick(3);
        check("power down", pdown, 1'h1);
        check("polling off", poll, 1'h0);
        dsr_rst = 1'h1;
        strobe(dsr_wr);
        tick(1);
        check("rate reset core", core_rst, 1'h1);
        tick(1);
        check("rate reset ends", core_rst, 1'h0);
        tick(2);
        check("status two soft reset", st2, 8'h00);
        check("power down exit", pdown, 1'h0);
        check("polling restarts", poll, 1'h1);
        check("density kept", dens_o, dens_hi);
        check("reset bit clear", dor_bit, 1'h0);
        {dor_rst, dsr_wr, dor_wr} = 3'h7;
        tick(1);
        {dsr_wr, dor_wr} = 2'h0;
        tick(4);
        check("both resets core", core_rst, 1'h1);
        check("both resets bit", dor_bit, 1'h1);
        dor_rst = 1'h0;
        strobe(dor_wr);
        tick(2);
        check("host clears reset", core_rst, 1'h0);
        check("density kept", dens_o, dens_hi);
        f0 = 8'h06;
        strobe(cfg_wr);
        hw_n = 1'h0;
        tick(2);
        check("pin reset bit", dor_bit, 1'h1);
        check("pin reset core", core_rst, 1'h1);
        check("pin reset density", dens_o, 1'h1);
        hw_n = 1'h1;
        tick(1);
        strobe(dor_wr);
        {stall, xfer} = 2'h3;
        tick(3);
        check("specify kept", dreq, 1'h1);
        check("density held", dens_o, 1'h1);
        {stall, xfer} = 2'h0;
        tick(2);
        results();
    end
endmodule
`default_nettype wire
